// ### hw/rclk_pkg.sv
// Operation
// - with neither lock bit programmed, verify reads return internal program memory contents.
// - once a key is present, every verify byte is the encrypted form of the code byte.
// - the encrypted byte is the code byte xnor one key byte, and key bytes are never readable.
// - with the first lock bit programmed, table reads run from external memory get no internal bytes.
// - with the first lock bit programmed, the fetch select is latched at reset and later pin changes are ignored.
// - with the first lock bit programmed, any further code programming is refused.
// - with both lock bits programmed, verify mode is disabled entirely.
// - the 64-byte key array starts all ones.
// - the key sits at 4000h to 403fh, and a key byte of ffh means no encryption.
// - the lock byte at 4040h holds lock bit one in bit 0 and two in bit 1, 0 meaning enabled.
// - only unprogrammed, first-only and both-programmed lock states have defined protection.
package rclk_pkg;
  localparam int RCLK_AW = 15;
  localparam logic [14:0] RCLK_CODE_LAST = 15'h3fff;
  localparam logic [14:0] RCLK_KEY_BASE = 15'h4000;
  localparam logic [14:0] RCLK_KEY_LAST = 15'h403f;
  localparam logic [14:0] RCLK_LOCK_ADDR = 15'h4040;
  localparam int RCLK_LOCK1_BIT = 0;
  localparam int RCLK_LOCK2_BIT = 1;
  localparam logic [7:0] RCLK_KEY_RESET = 8'hff;
  localparam logic [7:0] RCLK_LOCK_RESET = 8'hff;
  localparam int RCLK_KEY_DEPTH = 64;
  localparam logic RCLK_FETCH_RESET = 1'b0;
  localparam logic [7:0] RCLK_BLANK_BYTE = 8'h00;
  typedef enum logic [1:0] {RCLK_OPEN, RCLK_LOCK1, RCLK_LOCK12, RCLK_UNDEF} rclk_prot_t;
endpackage

// ### hw/rclk_key_store.sv
`timescale 1ns/1ps
// key array: written by the image loader, read only through the cipher path
module rclk_key_store
  import rclk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [5:0] rd_idx,
  output logic [7:0] rd_key,
  output logic key_present
);
  logic [7:0] key_reg [RCLK_KEY_DEPTH];
  logic [RCLK_KEY_DEPTH-1:0] used;

  // one storage byte per slot, reset to unprogrammed ones
  genvar g;
  generate
    for (g = 0; g < RCLK_KEY_DEPTH; g++) begin : g_key
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          key_reg[g] <= RCLK_KEY_RESET;
        end else if (wr_en && wr_idx == 6'(g)) begin
          key_reg[g] <= wr_data;
        end
      end
      assign used[g] = (key_reg[g] != RCLK_KEY_RESET);
    end
  endgenerate

  assign rd_key = key_reg[rd_idx];
  assign key_present = |used;
endmodule // rclk_key_store

// ### hw/rclk_lock.sv
`timescale 1ns/1ps
// protection logic: image loading, lock byte, fetch select, verify and table read gating
module rclk_lock
  import rclk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic load_en,
  input wire logic [14:0] load_addr,
  input wire logic [7:0] load_data,
  output logic load_refused,
  input wire logic in_reset,
  input wire logic external_fetch_select_pin,
  output logic external_fetch_select,
  input wire logic program_strobe,
  input wire logic verify_en,
  input wire logic [13:0] verify_addr,
  output logic [7:0] verify_data,
  output logic verify_valid,
  input wire logic code_table_read,
  input wire logic exec_external,
  input wire logic [13:0] table_addr,
  output logic [7:0] table_data,
  output logic table_allowed,
  output logic [7:0] code_wr_data,
  output logic [13:0] code_wr_addr,
  output logic code_wr_en,
  output logic [13:0] code_rd_addr,
  input wire logic [7:0] code_rd_data,
  output logic first_lock_bit,
  output logic second_lock_bit,
  output logic undefined_lock
);
  // lock byte as stored, active low like the image
  logic [7:0] lock_reg;
  logic [7:0] lock_next;

  // fetch select as seen by the core
  logic fetch_sel_reg;

  // verify answer and its valid flag
  logic [7:0] verify_data_reg;
  logic verify_valid_reg;

  // table read answer and its grant flag
  logic [7:0] table_data_reg;
  logic table_ok_reg;

  // key store read side
  logic [7:0] key_byte;
  logic key_present;

  // decoded load strobes
  logic load_take;
  logic load_code_area;
  logic load_key_area;
  logic load_lock_area;
  logic key_wr;
  logic lock_wr;

  // decoded verify and table conditions
  logic verify_open;
  logic verify_take;
  logic [7:0] verify_byte;
  logic table_take;
  logic table_blocked;
  rclk_prot_t prot;

  // decode lock byte (0 = enabled) into a protection level
  function automatic rclk_prot_t prot_of(input logic [7:0] lb);
    case ({lb[RCLK_LOCK2_BIT], lb[RCLK_LOCK1_BIT]})
      2'b11: prot_of = RCLK_OPEN;
      2'b10: prot_of = RCLK_LOCK1;
      2'b00: prot_of = RCLK_LOCK12;
      default: prot_of = RCLK_UNDEF;
    endcase
  endfunction

  // true for image addresses inside the user code area
  function automatic logic is_code(input logic [14:0] a);
    is_code = (a <= RCLK_CODE_LAST);
  endfunction

  // true for image addresses inside the key area
  function automatic logic is_key(input logic [14:0] a);
    is_key = (a >= RCLK_KEY_BASE) && (a <= RCLK_KEY_LAST);
  endfunction

  // true for the lock byte address
  function automatic logic is_lock(input logic [14:0] a);
    is_lock = (a == RCLK_LOCK_ADDR);
  endfunction

  // only the open and first-lock levels present verify data
  function automatic logic verify_allowed(input rclk_prot_t p);
    verify_allowed = (p == RCLK_OPEN) || (p == RCLK_LOCK1);
  endfunction

  // verify byte: code xnor key once any key byte is set, plain otherwise
  function automatic logic [7:0] cipher_of(input logic [7:0] code, input logic [7:0] key, input logic armed);
    cipher_of = armed ? ~(code ^ key) : code;
  endfunction

  // lock byte update: bits only clear, lock two needs lock one now or in the same write
  function automatic logic [7:0] lock_merge(input logic [7:0] cur, input logic [7:0] wr);
    logic [7:0] nxt;
    nxt = cur;
    nxt[RCLK_LOCK1_BIT] = cur[RCLK_LOCK1_BIT] & wr[RCLK_LOCK1_BIT];
    nxt[RCLK_LOCK2_BIT] = cur[RCLK_LOCK2_BIT]
      & (wr[RCLK_LOCK2_BIT] | (wr[RCLK_LOCK1_BIT] & cur[RCLK_LOCK1_BIT]));
    lock_merge = nxt;
  endfunction

  // protection level and lock outputs (1 = programmed)
  assign prot = prot_of(lock_reg);
  assign first_lock_bit = ~lock_reg[RCLK_LOCK1_BIT];
  assign second_lock_bit = ~lock_reg[RCLK_LOCK2_BIT];
  assign undefined_lock = (prot == RCLK_UNDEF);

  // load decode: a load is taken on an edge with enable and strobe both high
  assign load_take = load_en && program_strobe;
  assign load_code_area = is_code(load_addr);
  assign load_key_area = is_key(load_addr);
  assign load_lock_area = is_lock(load_addr);

  // code and key writes stop once the first lock bit is programmed
  assign load_refused = load_take && first_lock_bit && (load_code_area || load_key_area);
  assign code_wr_en = load_take && !first_lock_bit && load_code_area;
  assign key_wr = load_take && !first_lock_bit && load_key_area;
  assign lock_wr = load_take && load_lock_area;

  // write port to the code store carries the low address bits only
  assign code_wr_addr = load_addr[13:0];
  assign code_wr_data = load_data;

  // next lock byte; lock bits stay writable after the first lock
  assign lock_next = lock_merge(lock_reg, load_data);

  // lock byte only ever moves toward more protection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= RCLK_LOCK_RESET;
    end else if (lock_wr) begin
      lock_reg <= lock_next;
    end
  end

  // key array; its bytes leave only through the cipher below
  rclk_key_store u_key (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_en(key_wr),
    .wr_idx(load_addr[5:0]),
    .wr_data(load_data),
    .rd_idx(verify_addr[5:0]),
    .rd_key(key_byte),
    .key_present(key_present)
  );

  // fetch select follows the pin while unlocked; once locked only the reset phase samples it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_sel_reg <= RCLK_FETCH_RESET;
    end else if (in_reset || !first_lock_bit) begin
      fetch_sel_reg <= external_fetch_select_pin;
    end
  end
  // output straight from the flop
  assign external_fetch_select = fetch_sel_reg;

  // one shared code read port: verify has priority over table reads
  assign code_rd_addr = verify_en ? verify_addr : table_addr;

  // verify request decode and the byte it would present
  assign verify_open = verify_allowed(prot);
  assign verify_take = verify_en && verify_open;
  assign verify_byte = cipher_of(code_rd_data, key_byte, key_present);

  // verify valid flag: one cycle after each accepted request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      verify_valid_reg <= 1'b0;
    end else begin
      verify_valid_reg <= verify_take;
    end
  end

  // verify data: cipher output (plain until a key byte is set) when accepted, blank otherwise so nothing leaks at full lock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      verify_data_reg <= RCLK_BLANK_BYTE;
    end else if (verify_take) begin
      verify_data_reg <= verify_byte;
    end else begin
      verify_data_reg <= RCLK_BLANK_BYTE;
    end
  end
  // outputs straight from the flops
  assign verify_data = verify_data_reg;
  assign verify_valid = verify_valid_reg;

  // table read decode: verify owns the read port, external code is shut out once locked
  assign table_take = code_table_read && !verify_en;
  assign table_blocked = first_lock_bit && exec_external;

  // table grant flag: one cycle after each table read that is taken (no verify request) and not blocked
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_ok_reg <= 1'b0;
    end else begin
      table_ok_reg <= table_take && !table_blocked;
    end
  end

  // table data: plain code byte when granted, blank when blocked, held when idle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_data_reg <= RCLK_BLANK_BYTE;
    end else if (table_take) begin
      table_data_reg <= table_blocked ? RCLK_BLANK_BYTE : code_rd_data;
    end
  end
  // outputs straight from the flops
  assign table_data = table_data_reg;
  assign table_allowed = table_ok_reg;
endmodule // rclk_lock

// ### sim/rclk_checker.sv
`timescale 1ns/1ps
module rclk_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic load_en,
  input wire logic program_strobe,
  input wire logic load_refused,
  input wire logic code_wr_en,
  input wire logic in_reset,
  input wire logic external_fetch_select_pin,
  input wire logic external_fetch_select,
  input wire logic verify_en,
  input wire logic verify_valid,
  input wire logic code_table_read,
  input wire logic exec_external,
  input wire logic table_allowed,
  input wire logic first_lock_bit,
  input wire logic second_lock_bit,
  input wire logic undefined_lock,
  input wire logic [14:0] load_addr,
  input wire logic [13:0] code_wr_addr,
  input wire logic [7:0] load_data,
  input wire logic [7:0] code_wr_data,
  input wire logic [7:0] verify_data,
  input wire logic [7:0] table_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // verify request while verify mode is open
  sequence s_vreq;
    verify_en && !second_lock_bit && !undefined_lock;
  endsequence
  AST_VERIFY_OPEN: assert property (s_vreq |=> verify_valid) else $error("verify not answered");
  AST_VERIFY_OFF: assert property (verify_en && second_lock_bit |=> !verify_valid && verify_data == 8'h00)
    else $error("verify answered while locked");
  AST_UNDEF: assert property (verify_valid |-> !$past(undefined_lock) && !$past(second_lock_bit))
    else $error("verify answered at undefined or full lock");
  AST_REFUSE: assert property (load_en && program_strobe && first_lock_bit && load_addr <= 15'h403f
    |-> load_refused && !code_wr_en) else $error("locked load not refused");
  AST_WRITE: assert property (load_en && program_strobe && !first_lock_bit && load_addr <= 15'h3fff
    |-> code_wr_en && code_wr_addr == load_addr[13:0] && code_wr_data == load_data) else $error("code write lost");
  AST_TABLE: assert property (code_table_read && exec_external && first_lock_bit && !verify_en
    |=> !table_allowed && table_data == 8'h00) else $error("table read leaked");
  AST_LATCH: assert property (in_reset |=> external_fetch_select == $past(external_fetch_select_pin))
    else $error("fetch select not sampled");
  AST_HOLD: assert property (first_lock_bit && !in_reset |=> $stable(external_fetch_select))
    else $error("fetch select moved");
  AST_PAIR: assert property (second_lock_bit |-> first_lock_bit) else $error("lock two without one");
endmodule // rclk_checker
bind rclk_lock rclk_checker chk_u (.*);

// ### sim/rclk_code_store.sv
`timescale 1ns/1ps
// external code store behind the lock block
module rclk_code_store (
  input wire logic sys_clk,
  input wire logic code_wr_en,
  input wire logic [13:0] code_wr_addr,
  input wire logic [13:0] code_rd_addr,
  input wire logic [7:0] code_wr_data,
  output logic [7:0] code_rd_data
);
  logic [7:0] mem [0:16383];
  // one byte per accepted load
  always_ff @(posedge sys_clk) begin
    if (code_wr_en) begin
      mem[code_wr_addr] <= code_wr_data;
    end
  end
  // combinational read port
  assign code_rd_data = mem[code_rd_addr];
endmodule // rclk_code_store

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, arst_n = 0, load_en = 0, program_strobe = 0, in_reset = 1, verify_en = 0, r;
  logic code_table_read = 0, exec_external = 0, external_fetch_select_pin = 1, external_fetch_select;
  logic load_refused, verify_valid, table_allowed, code_wr_en, first_lock_bit, second_lock_bit, undefined_lock;
  logic [14:0] load_addr = 0;
  logic [13:0] verify_addr = 0, table_addr = 0, code_wr_addr, code_rd_addr;
  logic [7:0] load_data = 0, verify_data, table_data, code_wr_data, code_rd_data;
  int miscompares = 0, tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  rclk_lock dut_u (.*);
  rclk_code_store mem_u (.*);
  task give_verdict;
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one image load, refusal flag sampled while held, then one idle cycle
  task ld(input logic [14:0] a, input logic [7:0] d);
    load_en = 1; program_strobe = 1; load_addr = a; load_data = d;
    #1 r = load_refused;
    @(negedge sys_clk);
    load_en = 0; program_strobe = 0;
    @(negedge sys_clk);
  endtask
  task vf(input logic [13:0] a, input logic [7:0] exp, input logic v);
    verify_en = 1; verify_addr = a;
    @(negedge sys_clk);
    verify_en = 0;
    chk(verify_data, exp);
    chk({7'h0, verify_valid}, {7'h0, v});
  endtask
  task t_open;
    ld(15'h0005, 8'h3c);
    vf(14'h0005, 8'h3c, 1);
    ld(15'h4005, 8'h0f);
    vf(14'h0005, 8'hcc, 1);
    ld(15'h4040, 8'hfd);
    chk({6'h0, second_lock_bit, first_lock_bit}, 8'h00);
  endtask
  task t_lock1;
    ld(15'h4040, 8'hfe);
    chk({6'h0, second_lock_bit, first_lock_bit}, 8'h01);
    ld(15'h0005, 8'h00);
    chk({7'h0, r}, 8'h01);
    vf(14'h0005, 8'hcc, 1);
    code_table_read = 1; table_addr = 14'h0005;
    @(negedge sys_clk);
    chk(table_data, 8'h3c);
    chk({7'h0, table_allowed}, 8'h01);
    exec_external = 1;
    @(negedge sys_clk);
    code_table_read = 0;
    chk(table_data, 8'h00);
    chk({7'h0, table_allowed}, 8'h00);
    external_fetch_select_pin = 0;
    repeat (2) @(negedge sys_clk);
    chk({7'h0, external_fetch_select}, 8'h01);
    in_reset = 1;
    @(negedge sys_clk);
    in_reset = 0;
    chk({7'h0, external_fetch_select}, 8'h00);
  endtask
  task t_lock2;
    ld(15'h4040, 8'hfc);
    chk({6'h0, second_lock_bit, first_lock_bit}, 8'h03);
    vf(14'h0005, 8'h00, 0);
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    arst_n = 1;
    @(negedge sys_clk);
    in_reset = 0;
    t_open;
    t_lock1;
    t_lock2;
    give_verdict;
  end
  // watchdog, far beyond the few dozen cycles the tests need
  initial begin
    repeat (500) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end
endmodule // tb
